/* File: imc_pkg.sv */
`default_nettype none

package imc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BOOT_TIME_US = 10_000;
	// Longest time, so the count rounds down
	localparam int unsigned BOOT_CYCLES = BOOT_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned BASE_RATE_HZ = 7680;
	localparam int unsigned BASE_DIV = CLK_HZ / BASE_RATE_HZ;
	localparam int unsigned TICK_W = 13;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_LR_SETUP = 8'h00;
	localparam logic [7:0] OFF_HR_SETUP = 8'h04;
	localparam logic [7:0] OFF_GY_SETUP = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_SAMPLE = 8'h10;

	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	localparam int unsigned RATE_LSB = 0;
	localparam int unsigned MODE_LSB = 4;
	localparam int unsigned HR_RATE_LSB = 0;
	localparam int unsigned HR_PRECISE_BIT = 4;
	localparam logic [3:0] RATE_OFF = 4'h0;
	localparam logic [3:0] RATE_SLOWEST = 4'h1;
	localparam logic [3:0] RATE_CAP_SAVING = 4'h7;
	localparam logic [3:0] RATE_CAP_NORMAL = 4'ha;
	localparam logic [3:0] RATE_CAP_FULL = 4'hc;
	localparam logic [3:0] TICK_SHIFT_MAX = 4'hc;
	localparam logic [2:0] HR_RATE_OFF = 3'h0;
	localparam logic [1:0] AVG_SHIFT_2 = 2'h1;
	localparam logic [1:0] AVG_SHIFT_4 = 2'h2;
	localparam logic [1:0] AVG_SHIFT_8 = 2'h3;
	localparam logic [1:0] AVG_SHIFT_1 = 2'h0;

	typedef enum logic [2:0] {
		LR_FULL_PERF = 3'b000,
		LR_PRECISE = 3'b001,
		LR_RSVD_A = 3'b010,
		LR_EXT_TRIG = 3'b011,
		LR_SAVING_AVG2 = 3'b100,
		LR_SAVING_AVG4 = 3'b101,
		LR_SAVING_AVG8 = 3'b110,
		LR_NORMAL = 3'b111
	} imc_lr_mode_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} imc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} imc_apb_rsp_t;

	typedef struct packed {
		logic [19:0] zero;
		logic combo_err;
		logic rate_err;
		logic mode_err;
		logic gyro_active;
		logic hr_active;
		logic [2:0] mode;
		logic filter_en;
		logic chain_on;
		logic lr_active;
		logic boot_done;
	} imc_status_t;

endpackage : imc_pkg

`default_nettype wire

/* File: imc_avg.sv */
`timescale 1ns/1ns
`default_nettype none

module imc_avg #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned MAX_SHIFT = 3
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Control
	input wire logic clear,
	input wire logic [1:0] shift,
	// Measurements in
	input wire logic in_valid,
	input wire logic signed [WIDTH-1:0] in_data,
	// Averaged sample out
	output logic out_valid,
	output logic signed [WIDTH-1:0] out_data
);

	localparam int unsigned SUM_W = WIDTH + MAX_SHIFT;

	if (MAX_SHIFT < 3 || WIDTH < 2) begin : g_chk
		$error("imc_avg: WIDTH or MAX_SHIFT too small");
	end

	logic signed [SUM_W-1:0] sum_reg;
	logic [3:0] count_reg;
	logic signed [SUM_W-1:0] sum_next;
	logic [3:0] need;

	assign sum_next = sum_reg + SUM_W'(in_data);
	assign need = 4'h1 << shift;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			sum_reg <= '0;
			count_reg <= 4'h0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			if (in_valid) begin
				if (count_reg + 4'h1 >= need) begin
					sum_reg <= '0;
					count_reg <= 4'h0;
					out_valid <= 1'b1;
				end else begin
					sum_reg <= sum_next;
					count_reg <= count_reg + 4'h1;
				end
			end
		end
	end

	// Arithmetic shift keeps the sign of the averaged sample
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			out_data <= '0;
		end else if (in_valid && count_reg + 4'h1 >= need) begin
			out_data <= WIDTH'(sum_next >>> shift);
		end
	end

endmodule : imc_avg

`default_nettype wire

/* File: imc_power_ctrl.sv */
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module imc_power_ctrl #(
	parameter int unsigned BOOT_CYCLES = imc_pkg::BOOT_CYCLES,
	parameter int unsigned BASE_DIV = imc_pkg::BASE_DIV,
	parameter int unsigned SAMPLE_W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register bus
	input wire imc_pkg::imc_apb_req_t apb_req,
	output imc_pkg::imc_apb_rsp_t apb_rsp,
	// Low-range front end
	output logic meas_req,
	input wire logic meas_valid,
	input wire logic signed [SAMPLE_W-1:0] meas_data,
	output logic lr_chain_on,
	output logic lr_aa_filter_en,
	output logic signed [SAMPLE_W-1:0] lr_sample,
	output logic lr_sample_valid,
	// External rate reference pin
	input wire logic ext_ref,
	// Other channels
	output logic hr_enable,
	output logic hr_precise,
	output logic gyro_enable,
	output logic gyro_tick,
	output logic boot_done
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (BOOT_CYCLES < 2 || BASE_DIV < 2 || SAMPLE_W < 2) begin : g_chk
		$error("imc_power_ctrl: parameter out of range");
	end

	localparam int unsigned BOOT_W = $clog2(BOOT_CYCLES + 1);
	localparam int unsigned DIV_W = $clog2(BASE_DIV + 1);
	localparam int unsigned TW = imc_pkg::TICK_W;

	typedef enum logic [1:0] {
		PH_BOOT = 2'b00,
		PH_IDLE = 2'b01,
		PH_MEASURE = 2'b10
	} imc_state_t;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	imc_state_t state_reg;
	logic [BOOT_W-1:0] boot_cnt_reg;
	logic [DIV_W-1:0] div_cnt_reg;
	logic base_tick_reg;
	logic [TW-1:0] grid_reg;
	logic [3:0] lr_rate_reg;
	logic [2:0] lr_mode_reg;
	logic [2:0] hr_rate_reg;
	logic hr_precise_sel_reg;
	logic [3:0] gy_rate_reg;
	logic [2:0] gy_mode_reg;
	logic ref_s1_reg;
	logic ref_s2_reg;
	logic ref_s3_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic lr_on;
	logic saving;
	logic continuous;
	logic [1:0] avg_shift;
	logic [3:0] rate_cap;
	logic [3:0] rate_eff;
	logic rate_err;
	logic mode_err;
	logic combo_err;
	logic lr_tick;
	logic ext_edge;
	logic avg_valid;
	logic signed [SAMPLE_W-1:0] avg_data;
	logic avg_clear;
	logic chain_next;
	logic wr_en;
	logic setup;
	logic [3:0] meas_cnt_reg;
	logic last_meas;
	imc_pkg::imc_status_t status;
	imc_pkg::imc_lr_mode_t lr_mode;

	assign lr_mode = imc_pkg::imc_lr_mode_t'(lr_mode_reg);

	// ----------------------------------------------------------------
	// Grid mask: period in base ticks is a power of two per rate code
	// ----------------------------------------------------------------
	function automatic logic [TW-1:0] tick_mask(input logic [3:0] code);
		logic [3:0] sh;
		if (code == imc_pkg::RATE_SLOWEST) begin
			sh = imc_pkg::TICK_SHIFT_MAX;
		end else begin
			sh = imc_pkg::TICK_SHIFT_MAX - code;
		end
		return (TW'(1) << sh) - TW'(1);
	endfunction : tick_mask

	// ----------------------------------------------------------------
	// Boot sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			boot_cnt_reg <= '0;
			boot_done <= 1'b0;
		end else if (!boot_done) begin
			boot_cnt_reg <= boot_cnt_reg + BOOT_W'(1);
			if (boot_cnt_reg == BOOT_W'(BOOT_CYCLES - 1)) begin
				boot_done <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	always_comb begin
		saving = 1'b0;
		avg_shift = imc_pkg::AVG_SHIFT_1;
		mode_err = 1'b0;
		rate_cap = imc_pkg::RATE_CAP_FULL;
		case (lr_mode)
			imc_pkg::LR_FULL_PERF: rate_cap = imc_pkg::RATE_CAP_FULL;
			imc_pkg::LR_PRECISE: rate_cap = imc_pkg::RATE_CAP_FULL;
			imc_pkg::LR_EXT_TRIG: rate_cap = imc_pkg::RATE_CAP_FULL;
			imc_pkg::LR_NORMAL: rate_cap = imc_pkg::RATE_CAP_NORMAL;
			imc_pkg::LR_SAVING_AVG2: begin
				saving = 1'b1;
				avg_shift = imc_pkg::AVG_SHIFT_2;
				rate_cap = imc_pkg::RATE_CAP_SAVING;
			end
			imc_pkg::LR_SAVING_AVG4: begin
				saving = 1'b1;
				avg_shift = imc_pkg::AVG_SHIFT_4;
				rate_cap = imc_pkg::RATE_CAP_SAVING;
			end
			imc_pkg::LR_SAVING_AVG8: begin
				saving = 1'b1;
				avg_shift = imc_pkg::AVG_SHIFT_8;
				rate_cap = imc_pkg::RATE_CAP_SAVING;
			end
			// Reserved code runs as full performance and is flagged
			default: mode_err = 1'b1;
		endcase
	end

	assign continuous = !saving;
	assign lr_on = boot_done && (lr_rate_reg != imc_pkg::RATE_OFF);
	assign rate_err = lr_on && (lr_rate_reg > rate_cap);
	assign rate_eff = rate_err ? rate_cap : lr_rate_reg;
	// Only full and precise modes may share with the high-range channel; flagged only
	assign combo_err = hr_enable && lr_on && !(lr_mode == imc_pkg::LR_FULL_PERF
		|| lr_mode == imc_pkg::LR_PRECISE);

	// ----------------------------------------------------------------
	// Base rate divider and shared sample grid
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_cnt_reg <= '0;
			base_tick_reg <= 1'b0;
		end else begin
			base_tick_reg <= 1'b0;
			if (div_cnt_reg == DIV_W'(BASE_DIV - 1)) begin
				div_cnt_reg <= '0;
				base_tick_reg <= 1'b1;
			end else begin
				div_cnt_reg <= div_cnt_reg + DIV_W'(1);
			end
		end
	end

	// One free grid for both channels keeps their periods nested
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			grid_reg <= '0;
		end else if (base_tick_reg) begin
			grid_reg <= grid_reg + TW'(1);
		end
	end

	// ----------------------------------------------------------------
	// External reference pin
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ref_s1_reg <= 1'b0;
			ref_s2_reg <= 1'b0;
			ref_s3_reg <= 1'b0;
		end else begin
			ref_s1_reg <= ext_ref;
			ref_s2_reg <= ref_s1_reg;
			ref_s3_reg <= ref_s2_reg;
		end
	end

	assign ext_edge = ref_s2_reg && !ref_s3_reg;
	assign lr_tick = (lr_mode == imc_pkg::LR_EXT_TRIG) ? ext_edge :
		(base_tick_reg && (grid_reg & tick_mask(rate_eff)) == '0);

	// ----------------------------------------------------------------
	// Reading chain sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= PH_BOOT;
			meas_req <= 1'b0;
		end else begin
			meas_req <= 1'b0;
			case (state_reg)
				PH_BOOT: begin
					if (boot_done) begin
						state_reg <= PH_IDLE;
					end
				end
				PH_IDLE: begin
					if (lr_on && lr_tick) begin
						state_reg <= PH_MEASURE;
						meas_req <= 1'b1;
					end
				end
				PH_MEASURE: begin
					if (!lr_on) begin
						state_reg <= PH_IDLE;
					end else if (avg_valid) begin
						state_reg <= PH_IDLE;
					end else if (meas_valid && !last_meas) begin
						meas_req <= 1'b1;
					end
				end
				default: state_reg <= PH_IDLE;
			endcase
		end
	end

	assign avg_clear = (state_reg != PH_MEASURE) || !lr_on;

	// Counts measurements so that none is requested past the last of a sample
	always_ff @(posedge sys_clk) begin
		if (sys_rst || avg_clear) begin
			meas_cnt_reg <= 4'h0;
		end else if (meas_valid) begin
			meas_cnt_reg <= meas_cnt_reg + 4'h1;
		end
	end

	// At least, not equal: a mode change mid-sample must not strand the count
	assign last_meas = (meas_cnt_reg + 4'h1) >= (4'h1 << avg_shift);

	imc_avg #(
		.WIDTH(SAMPLE_W),
		.MAX_SHIFT(3)
	) u_avg (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clear(avg_clear),
		.shift(avg_shift),
		.in_valid(meas_valid && state_reg == PH_MEASURE && lr_on),
		.in_data(meas_data),
		.out_valid(avg_valid),
		.out_data(avg_data)
	);

	// Output register is frozen whenever the channel is down
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lr_sample <= '0;
			lr_sample_valid <= 1'b0;
		end else begin
			lr_sample_valid <= avg_valid && lr_on;
			if (avg_valid && lr_on) begin
				lr_sample <= avg_data;
			end
		end
	end

	// Saving modes power the chain only while measuring
	always_comb begin
		if (!lr_on) begin
			chain_next = 1'b0;
		end else if (continuous) begin
			chain_next = 1'b1;
		end else begin
			chain_next = (state_reg == PH_MEASURE && !avg_valid) || (state_reg == PH_IDLE && lr_tick);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lr_chain_on <= 1'b0;
			lr_aa_filter_en <= 1'b0;
		end else begin
			lr_chain_on <= chain_next;
			lr_aa_filter_en <= lr_on && continuous;
		end
	end

	// ----------------------------------------------------------------
	// High-range and gyro channels
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hr_enable <= 1'b0;
			hr_precise <= 1'b0;
		end else begin
			// Independent of low-range state, so it may run alone
			hr_enable <= boot_done && hr_rate_reg != imc_pkg::HR_RATE_OFF;
			hr_precise <= boot_done && hr_rate_reg != imc_pkg::HR_RATE_OFF
				&& hr_precise_sel_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gyro_enable <= 1'b0;
			gyro_tick <= 1'b0;
		end else begin
			gyro_enable <= boot_done && gy_rate_reg != imc_pkg::RATE_OFF;
			gyro_tick <= boot_done && gy_rate_reg != imc_pkg::RATE_OFF && base_tick_reg
				&& (grid_reg & tick_mask(gy_rate_reg)) == '0;
		end
	end

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	assign setup = apb_req.psel && !apb_req.penable;
	// A write refused at setup stays refused even if boot ends before access
	assign wr_en = apb_req.psel && apb_req.penable && pready_reg && apb_req.pwrite
		&& !pslverr_reg;

	always_comb begin
		status = '0;
		status.boot_done = boot_done;
		status.lr_active = lr_on;
		status.chain_on = lr_chain_on;
		status.filter_en = lr_aa_filter_en;
		status.mode = lr_mode_reg;
		status.hr_active = hr_enable;
		status.gyro_active = gyro_enable;
		status.mode_err = mode_err;
		status.rate_err = rate_err;
		status.combo_err = combo_err;
	end

	// Zero wait: every access completes in its first access cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				pslverr_reg <= 1'b0;
				prdata_reg <= '0;
				case (apb_req.paddr)
					imc_pkg::OFF_LR_SETUP: prdata_reg <= 32'(
						{lr_mode_reg, lr_rate_reg});
					imc_pkg::OFF_HR_SETUP: prdata_reg <= 32'(
						{hr_precise_sel_reg, 1'b0, hr_rate_reg});
					imc_pkg::OFF_GY_SETUP: prdata_reg <= 32'({gy_mode_reg, gy_rate_reg});
					imc_pkg::OFF_STATUS: prdata_reg <= status;
					imc_pkg::OFF_SAMPLE: prdata_reg <= 32'(lr_sample);
					default: pslverr_reg <= 1'b1;
				endcase
				if (apb_req.pwrite && !boot_done) begin
					pslverr_reg <= 1'b1;
				end
			end
		end
	end

	// Configuration survives power-down; only boot clears it
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !boot_done) begin
			lr_rate_reg <= imc_pkg::RATE_OFF;
			lr_mode_reg <= imc_pkg::LR_FULL_PERF;
			hr_rate_reg <= imc_pkg::HR_RATE_OFF;
			hr_precise_sel_reg <= 1'b0;
			gy_rate_reg <= imc_pkg::RATE_OFF;
			gy_mode_reg <= 3'h0;
		end else if (wr_en) begin
			case (apb_req.paddr)
				imc_pkg::OFF_LR_SETUP: begin
					lr_rate_reg <= apb_req.pwdata[imc_pkg::RATE_LSB +: 4];
					lr_mode_reg <= apb_req.pwdata[imc_pkg::MODE_LSB +: 3];
				end
				imc_pkg::OFF_HR_SETUP: begin
					hr_rate_reg <= apb_req.pwdata[imc_pkg::HR_RATE_LSB +: 3];
					hr_precise_sel_reg <= apb_req.pwdata[imc_pkg::HR_PRECISE_BIT];
				end
				imc_pkg::OFF_GY_SETUP: begin
					gy_rate_reg <= apb_req.pwdata[imc_pkg::RATE_LSB +: 4];
					gy_mode_reg <= apb_req.pwdata[imc_pkg::MODE_LSB +: 3];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		apb_rsp.prdata = prdata_reg;
		apb_rsp.pready = pready_reg;
		apb_rsp.pslverr = pslverr_reg;
	end

endmodule : imc_power_ctrl

`default_nettype wire

/* File: imc_power_ctrl_asserts.sv */
`timescale 1ns/1ns
`default_nettype none

module imc_power_ctrl_chk #(
	parameter int unsigned BOOT_CYCLES = 20,
	parameter int unsigned SAMPLE_W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register bus
	input wire imc_pkg::imc_apb_req_t apb_req,
	input wire imc_pkg::imc_apb_rsp_t apb_rsp,
	// Channel side
	input wire logic meas_req,
	input wire logic meas_valid,
	input wire logic lr_chain_on,
	input wire logic lr_aa_filter_en,
	input wire logic signed [SAMPLE_W-1:0] lr_sample,
	input wire logic lr_sample_valid,
	input wire logic hr_enable,
	input wire logic gyro_enable,
	input wire logic boot_done
);
	// Saturates shortly after the boot window so it never wraps
	int unsigned boot_cnt;
	logic mapped;

	assign mapped = apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			boot_cnt <= 0;
		end else if (boot_cnt < BOOT_CYCLES + 8) begin
			boot_cnt <= boot_cnt + 1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_done;
		apb_req.psel && apb_req.penable && apb_rsp.pready;
	endsequence

	boot_quiet_a: assert property (boot_cnt + 2 < BOOT_CYCLES |->
		!boot_done && !hr_enable && !gyro_enable && !lr_chain_on) else $error("active in boot");
	boot_end_a: assert property (boot_cnt > BOOT_CYCLES + 2 |-> boot_done)
		else $error("boot late");
	bus_answer_a: assert property (s_setup |=> s_done)
		else $error("no bus answer");
	early_write_a: assert property (s_done ##0 (apb_req.pwrite && !boot_done) |->
		apb_rsp.pslverr) else $error("write in boot taken");
	bad_addr_a: assert property (s_done ##0 !mapped |->
		apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped accepted");
	filter_chain_a: assert property (lr_aa_filter_en |-> lr_chain_on)
		else $error("filter without chain");
	sample_hold_a: assert property (!lr_sample_valid && !$past(sys_rst) |->
		$stable(lr_sample)) else $error("sample moved");
	sample_lat_a: assert property (lr_sample_valid |-> $past(meas_valid, 2))
		else $error("sample latency");
	req_pulse_a: assert property (meas_req |-> lr_chain_on ##1 !meas_req)
		else $error("request shape");
endmodule : imc_power_ctrl_chk

bind imc_power_ctrl imc_power_ctrl_chk #(.BOOT_CYCLES(BOOT_CYCLES), .SAMPLE_W(SAMPLE_W)) u_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.meas_req(meas_req), .meas_valid(meas_valid), .lr_chain_on(lr_chain_on),
	.lr_aa_filter_en(lr_aa_filter_en), .lr_sample(lr_sample),
	.lr_sample_valid(lr_sample_valid), .hr_enable(hr_enable), .gyro_enable(gyro_enable),
	.boot_done(boot_done)
);

`default_nettype wire

/* File: imc_front_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Reading chain stand-in: answers each request after lat extra cycles
module imc_front_model #(
	parameter int unsigned SAMPLE_W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Bench control
	input wire logic [3:0] lat,
	input wire logic signed [SAMPLE_W-1:0] base,
	// Front end
	input wire logic meas_req,
	output logic meas_valid,
	output logic signed [SAMPLE_W-1:0] meas_data
);
	logic busy;
	logic phase;
	logic [3:0] wait_cnt;
	logic signed [SAMPLE_W-1:0] last;
	logic signed [SAMPLE_W-1:0] fresh;

	// Alternating offset, so a wrong averaging count shows in the result
	assign fresh = base + {{(SAMPLE_W-2){1'b0}}, phase, 1'b0};

	always_ff @(posedge sys_clk) begin
		meas_valid <= 1'b0;
		// Data lines are not held outside the valid cycle
		meas_data <= ~last;
		if (sys_rst) begin
			busy <= 1'b0;
			phase <= 1'b0;
			wait_cnt <= 4'h0;
			last <= '0;
		end else if (meas_req) begin
			busy <= 1'b1;
			wait_cnt <= lat;
		end else if (busy && wait_cnt == 4'h0) begin
			busy <= 1'b0;
			meas_valid <= 1'b1;
			meas_data <= fresh;
			last <= fresh;
			phase <= ~phase;
		end else if (busy) begin
			wait_cnt <= wait_cnt - 4'h1;
		end
	end
endmodule : imc_front_model

`default_nettype wire

/* File: test_imc_power_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module test_imc_power_ctrl;
	localparam int unsigned BOOT = 20;
	// 300 us host wait at 100 MHz
	localparam int unsigned HOST_GAP = 30000;
	localparam logic [7:0] LR = imc_pkg::OFF_LR_SETUP;
	localparam logic [7:0] STAT = imc_pkg::OFF_STATUS;
	logic sys_clk = 1'b0;
	logic sys_rst, ext_ref, meas_req, meas_valid, lr_chain_on, lr_aa_filter_en, lr_sample_valid;
	logic hr_enable, hr_precise, gyro_enable, gyro_tick, boot_done, err;
	logic signed [15:0] meas_data, lr_sample, held;
	logic signed [15:0] base = 16'sh0100;
	logic [3:0] lat;
	logic [31:0] q;
	imc_pkg::imc_apb_req_t apb_req;
	imc_pkg::imc_apb_rsp_t apb_rsp;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int samp_cnt, req_cnt, tick_cnt;

	imc_power_ctrl #(.BOOT_CYCLES(BOOT), .BASE_DIV(4), .SAMPLE_W(16)) u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.meas_req(meas_req), .meas_valid(meas_valid), .meas_data(meas_data),
		.lr_chain_on(lr_chain_on), .lr_aa_filter_en(lr_aa_filter_en), .lr_sample(lr_sample),
		.lr_sample_valid(lr_sample_valid), .ext_ref(ext_ref), .hr_enable(hr_enable),
		.hr_precise(hr_precise), .gyro_enable(gyro_enable), .gyro_tick(gyro_tick),
		.boot_done(boot_done)
	);
	imc_front_model #(.SAMPLE_W(16)) u_front (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .lat(lat), .base(base),
		.meas_req(meas_req), .meas_valid(meas_valid), .meas_data(meas_data)
	);

	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			close_out();
		end
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 20);
		q = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		check("pready", apb_rsp.pready, 32'h1);
	endtask : apb

	task rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(what, q & m, e);
	endtask : rd_chk

	task count(input int cycles);
		repeat (cycles) begin
			@(posedge sys_clk);
			samp_cnt += (lr_sample_valid === 1'b1);
			req_cnt += (meas_req === 1'b1);
			tick_cnt += (gyro_tick === 1'b1);
		end
	endtask : count

	task wait_sample(input int lim);
		samp_cnt = 0;
		for (int i = 0; i < lim && samp_cnt == 0; i++) count(1);
		check("sample seen", samp_cnt, 32'h1);
	endtask : wait_sample

	task t_boot;
		rd_chk("boot early", STAT, 32'h1, 32'h0);
		apb(1'b1, LR, 32'h0c);
		check("boot write err", err, 32'h1);
		for (int i = 0; i < BOOT + 5 && boot_done !== 1'b1; i++) @(posedge sys_clk);
		check("boot done", boot_done, 32'h1);
		rd_chk("setup default", LR, 32'h7f, 32'h0);
		rd_chk("status idle", STAT, 32'hfff, 32'h1);
		check("outputs idle", {hr_enable, gyro_enable, lr_chain_on}, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped", {err, q[30:0]}, 32'h80000000);
	endtask : t_boot

	task t_full;
		apb(1'b1, LR, 32'h0c);
		rd_chk("full status", STAT, 32'hfff, 32'h00f);
		wait_sample(40);
		check("full sample", lr_sample === base || lr_sample === base + 16'sh2, 32'h1);
	endtask : t_full

	task t_saving;
		// Filter stays off in each saving mode; rate 7 raises no rate error, rate 12 is flagged
		lat <= 4'h5;
		for (int m = 4; m <= 6; m++) begin
			apb(1'b1, LR, {25'h0, m[2:0], 4'h7});
			rd_chk("lp status", STAT, 32'h408, 32'h000);
			wait_sample(400);
			req_cnt = 0;
			wait_sample(400);
			check("avg count", req_cnt, 32'h1 << (m - 3));
			check("avg value", lr_sample, base + 16'sh1);
			apb(1'b1, LR, {25'h0, m[2:0], 4'hc});
			rd_chk("lp rate cap", STAT, 32'h400, 32'h400);
		end
		lat <= 4'h1;
	endtask : t_saving

	task t_pdown;
		apb(1'b1, LR, 32'h47);
		wait_sample(400);
		held = lr_sample;
		apb(1'b1, LR, 32'h40);
		samp_cnt = 0;
		count(300);
		check("pdown samples", samp_cnt, 32'h0);
		check("pdown hold", lr_sample, held);
		check("pdown chain", lr_chain_on, 32'h0);
		rd_chk("pdown config", LR, 32'h7f, 32'h40);
		rd_chk("pdown status", STAT, 32'h2, 32'h0);
	endtask : t_pdown

	task t_modes;
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, LR, {25'h0, m[2:0], 4'hc});
			rd_chk("mode decode", STAT, 32'h270, {22'h0, m == 2, 2'b0, m[2:0], 4'h0});
		end
		// Normal mode: chain and filter on, a rate above 1920 Hz is clamped
		rd_chk("normal cap", STAT, 32'h40c, 32'h40c);
		apb(1'b1, LR, 32'h1c);
		count(40);
		check("precise chain", lr_chain_on, 32'h1);
		apb(1'b1, LR, 32'h3c);
		rd_chk("ext status", STAT, 32'h0e, 32'h0e);
		count(30);
		samp_cnt = 0;
		repeat (3) begin
			@(posedge sys_clk);
			ext_ref <= 1'b1;
			count(30);
			ext_ref <= 1'b0;
			count(30);
		end
		check("ext samples", samp_cnt, 32'h3);
	endtask : t_modes

	task t_switch;
		apb(1'b1, LR, 32'h0c);
		// High-range first, then the wait, then low-range off
		apb(1'b1, imc_pkg::OFF_HR_SETUP, 32'h13);
		rd_chk("hr with full", STAT, 32'h880, 32'h080);
		repeat (HOST_GAP) @(posedge sys_clk);
		apb(1'b1, LR, 32'h00);
		// The write lands at the access edge; the outputs follow one edge later
		repeat (2) @(posedge sys_clk);
		check("hr alone", {hr_enable, hr_precise, lr_chain_on}, 32'h6);
		apb(1'b1, imc_pkg::OFF_GY_SETUP, 32'h5c);
		rd_chk("hr gyro", STAT, 32'h982, 32'h180);
		tick_cnt = 0;
		count(300);
		check("gyro ticks", tick_cnt > 0 && gyro_enable === 1'b1, 32'h1);
		// Low-range first, then the wait, then high-range off
		apb(1'b1, LR, 32'h0c);
		repeat (HOST_GAP) @(posedge sys_clk);
		apb(1'b1, imc_pkg::OFF_HR_SETUP, 32'h0);
		repeat (2) @(posedge sys_clk);
		check("hr off", hr_enable, 32'h0);
	endtask : t_switch

	initial begin
		sys_rst = 1'b1;
		apb_req = '0;
		ext_ref = 1'b0;
		lat = 4'h1;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_boot();
		t_full();
		t_saving();
		t_pdown();
		t_modes();
		t_switch();
		close_out();
	end
endmodule : test_imc_power_ctrl

`default_nettype wire
